// ### design/ahap_pkg.sv
// Shared constants and types for the asynchronous host access port
package ahap_pkg;
  // Bus widths
  localparam int AHAP_ADDR_W = 24;
  localparam int AHAP_DATA_W = 32;
  // Clock and timing
  localparam int AHAP_CLK_PERIOD_PS = 50000;
  localparam int AHAP_READY_READ_MIN_PS = 28000;
  localparam int AHAP_READY_READ_CYC =
    (AHAP_READY_READ_MIN_PS + AHAP_CLK_PERIOD_PS - 1) / AHAP_CLK_PERIOD_PS;
  localparam int AHAP_READY_WRITE_MIN_PS = 7750;
  localparam int AHAP_READY_WRITE_CYC =
    (AHAP_READY_WRITE_MIN_PS + AHAP_CLK_PERIOD_PS - 1) / AHAP_CLK_PERIOD_PS;
  // Upper address line kept high so the first address is never in multiprocessor space
  localparam int AHAP_MPS_ESCAPE_BIT = 23;
  // Reset values
  localparam logic AHAP_RST_PIN_N = 1'b1;
  localparam logic AHAP_RST_OE = 1'b0;
  // Device and host sequencing states
  typedef enum logic [2:0] {
    AHAP_DEV_IDLE, AHAP_DEV_WAIT_GRANT, AHAP_DEV_GRANTED, AHAP_DEV_ACCESS, AHAP_DEV_DONE
  } ahap_dev_state_e;
  typedef enum logic [2:0] {
    AHAP_HST_IDLE, AHAP_HST_REQUEST, AHAP_HST_SETUP, AHAP_HST_STROBE, AHAP_HST_RELEASE,
    AHAP_HST_DROP
  } ahap_hst_state_e;
endpackage

// ### design/ahap_if.sv
// Pin bundle between the host and the device end of the host access port
`timescale 1ns/1ps
interface ahap_if #(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 32
);
  logic cs_n;
  logic host_bus_request_n;
  logic host_bus_grant_n;
  logic rd_n;
  logic wr_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] host_data_o;
  logic host_data_oe;
  logic [DATA_W-1:0] dev_data_o;
  logic dev_data_oe;
  logic host_ready_o;
  logic host_ready_oe;
  logic [DATA_W-1:0] data;
  logic host_ready;
  // Resolved wire levels; ready floats high through the pull-up
  assign data = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : '1);
  assign host_ready = host_ready_oe ? host_ready_o : 1'b1;
  modport device (
    input cs_n, host_bus_request_n, rd_n, wr_n, addr, data,
    output host_bus_grant_n, dev_data_o, dev_data_oe, host_ready_o, host_ready_oe
  );
  modport host (
    input host_bus_grant_n, host_ready, data,
    output cs_n, host_bus_request_n, rd_n, wr_n, addr, host_data_o, host_data_oe
  );
endinterface

// ### design/ahap_device.sv
// Device end: grants the bus to the host and paces register accesses with ready
// Functional notes
// R1: Grant precedes any host read or write strobe.
// R2: Accept writes spaced half a clock apart.
// R3: First address avoids multiprocessor space.
// R4: Host drives upper address high while granted; the host clears it when it drops the request, before grant is withdrawn.
// R5: Ready builds as open-drain or active-drive.
// R6: Ready low on request, released at grant.
// R7: Active-drive ready floats when request ends.
// R8: Read ready low until data valid.
// R9: Host holds read strobe until ready released.
// R10: Write ready low; host holds strobe.
// R11: Read address and select stable around strobe.
// R12: Bus request sampled on the input clock.
// R13: Grant driven from the clock edge.
`timescale 1ns/1ps
module ahap_device import ahap_pkg::*; #(
  parameter int ADDR_W = AHAP_ADDR_W,
  parameter int DATA_W = AHAP_DATA_W,
  parameter int REG_ADDR_W = 4,
  parameter bit READY_OPEN_DRAIN = 1'b0
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  // Host pins
  ahap_if.device pins,
  // Core side: grant permission and register write events
  input wire logic grant_allow_i,
  output logic granted_o,
  output logic wr_strobe_o,
  output logic [REG_ADDR_W-1:0] wr_addr_o,
  output logic [DATA_W-1:0] wr_data_o,
  output logic [15:0] write_count_o
);
  localparam int REGS = 1 << REG_ADDR_W;
  localparam int CNT_W = 8;

  // Register array reachable by the host
  logic [DATA_W-1:0] regs [REGS];

  // Pin synchronisers, two stages each; low address bits ride along
  logic [REG_ADDR_W+3:0] sync_a;
  logic [REG_ADDR_W+3:0] sync_b;
  logic [REG_ADDR_W-1:0] addr_s;
  logic req_s, cs_s, rd_s, wr_s;
  assign {addr_s, req_s, cs_s, rd_s, wr_s} = sync_b;

  ahap_dev_state_e state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic grant_n, next_grant_n;
  logic rdy_o, next_rdy_o, rdy_oe, next_rdy_oe;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic rdata_oe, next_rdata_oe;
  logic is_read, next_is_read;
  logic wstb, next_wstb;
  logic [REG_ADDR_W-1:0] waddr, next_waddr;
  logic [DATA_W-1:0] wdata, next_wdata;
  logic [15:0] wcount, next_wcount;

  // Two capture slots on the raw write strobe edge; one toggle per slot
  // A single toggle would flip twice inside one clock and the pair would vanish
  logic [REG_ADDR_W-1:0] cap_addr [2];
  logic [DATA_W-1:0] cap_data [2];
  logic cap_wsel;
  logic [1:0] cap_tog, cap_tog_s1, cap_tog_s2, cap_tog_seen, next_cap_tog_seen;
  logic cap_rsel, next_cap_rsel;

  // Ready drive helper: low while holding, released per build option
  function automatic logic [1:0] ready_drive(input logic hold);
    if (hold) begin
      ready_drive = 2'b10;
    end else if (READY_OPEN_DRAIN) begin
      ready_drive = 2'b00;
    end else begin
      ready_drive = 2'b11;
    end
  endfunction

  // Write capture on the strobe's own edge so closely spaced writes are kept
  always_ff @(posedge pins.wr_n or posedge reset_i) begin
    if (reset_i) begin
      cap_wsel <= 1'b0;
      cap_tog <= 2'b00;
    end else if (!pins.cs_n && !pins.host_bus_grant_n) begin // R1 R2
      cap_tog[cap_wsel] <= ~cap_tog[cap_wsel];
      cap_wsel <= ~cap_wsel;
    end
  end

  // Slot contents need no reset; a slot is only read after its toggle moves
  always_ff @(posedge pins.wr_n) begin
    if (!pins.cs_n && !pins.host_bus_grant_n) begin
      cap_addr[cap_wsel] <= pins.addr[REG_ADDR_W-1:0];
      cap_data[cap_wsel] <= pins.data;
    end
  end

  // Synchronisers: first stage feeds only the second
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync_a <= {{REG_ADDR_W{1'b0}}, 4'hF};
      sync_b <= {{REG_ADDR_W{1'b0}}, 4'hF};
      cap_tog_s1 <= 2'b00;
      cap_tog_s2 <= 2'b00;
    end else if (clk_en_i) begin
      sync_a <= {pins.addr[REG_ADDR_W-1:0], pins.host_bus_request_n, pins.cs_n, pins.rd_n,
                 pins.wr_n}; // R12
      sync_b <= sync_a;
      cap_tog_s1 <= cap_tog;
      cap_tog_s2 <= cap_tog_s1;
    end
  end

  // Next-state logic for grant, ready and access pacing
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_grant_n = grant_n;
    next_rdata = rdata;
    next_rdata_oe = rdata_oe;
    next_is_read = is_read;
    next_wstb = 1'b0;
    next_waddr = waddr;
    next_wdata = wdata;
    next_wcount = wcount;
    {next_rdy_oe, next_rdy_o} = {rdy_oe, rdy_o};
    next_cap_tog_seen = cap_tog_seen;
    next_cap_rsel = cap_rsel;
    // Slots drain in the order they were filled, one write event per clock
    if (cap_tog_s2[cap_rsel] != cap_tog_seen[cap_rsel]) begin // R2
      next_wstb = 1'b1;
      next_waddr = cap_addr[cap_rsel];
      next_wdata = cap_data[cap_rsel];
      next_wcount = wcount + 16'h0001;
      next_cap_tog_seen[cap_rsel] = cap_tog_s2[cap_rsel];
      next_cap_rsel = ~cap_rsel;
    end
    case (state)
      AHAP_DEV_IDLE: begin
        next_grant_n = 1'b1;
        next_rdata_oe = 1'b0;
        {next_rdy_oe, next_rdy_o} = 2'b00;
        if (!req_s && !cs_s) begin
          {next_rdy_oe, next_rdy_o} = ready_drive(1'b1); // R6
          next_state = AHAP_DEV_WAIT_GRANT;
        end
      end
      AHAP_DEV_WAIT_GRANT: begin
        if (req_s || cs_s) begin
          {next_rdy_oe, next_rdy_o} = 2'b00; // R7
          next_state = AHAP_DEV_IDLE;
        end else if (grant_allow_i) begin
          next_grant_n = 1'b0; // R13
          {next_rdy_oe, next_rdy_o} = ready_drive(1'b0); // R6
          next_state = AHAP_DEV_GRANTED;
        end
      end
      AHAP_DEV_GRANTED: begin
        next_rdata_oe = 1'b0;
        if (req_s) begin
          next_grant_n = 1'b1;
          {next_rdy_oe, next_rdy_o} = 2'b00; // R7
          next_state = AHAP_DEV_IDLE;
        end else if (cs_s) begin
          if (!READY_OPEN_DRAIN) begin
            {next_rdy_oe, next_rdy_o} = 2'b00; // R7
          end
        end else if (!rd_s || !wr_s) begin
          next_is_read = !rd_s;
          {next_rdy_oe, next_rdy_o} = ready_drive(1'b1); // R8 R10
          next_rdata = regs[addr_s];
          next_rdata_oe = !rd_s; // R8
          next_cnt = CNT_W'(!rd_s ? AHAP_READY_READ_CYC : AHAP_READY_WRITE_CYC);
          next_state = AHAP_DEV_ACCESS;
        end else begin
          {next_rdy_oe, next_rdy_o} = ready_drive(1'b0);
        end
      end
      AHAP_DEV_ACCESS: begin
        // Read data is driven a cycle before ready lets go
        if (is_read) begin
          next_rdata_oe = 1'b1;
        end
        if (cnt > CNT_W'(1)) begin
          next_cnt = cnt - CNT_W'(1);
        end else begin
          {next_rdy_oe, next_rdy_o} = ready_drive(1'b0); // R8
          next_state = AHAP_DEV_DONE;
        end
      end
      AHAP_DEV_DONE: begin
        // Wait for strobe release before the next access
        if (rd_s && wr_s) begin
          next_rdata_oe = 1'b0;
          next_state = AHAP_DEV_GRANTED;
        end
      end
      default: begin
        next_state = AHAP_DEV_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= AHAP_DEV_IDLE;
      cnt <= '0;
      grant_n <= AHAP_RST_PIN_N;
      rdy_o <= 1'b0;
      rdy_oe <= AHAP_RST_OE;
      rdata <= '0;
      rdata_oe <= AHAP_RST_OE;
      is_read <= 1'b0;
      wstb <= 1'b0;
      waddr <= '0;
      wdata <= '0;
      wcount <= '0;
      cap_tog_seen <= 2'b00;
      cap_rsel <= 1'b0;
    end else if (clk_en_i) begin
      state <= next_state;
      cnt <= next_cnt;
      grant_n <= next_grant_n;
      rdy_o <= next_rdy_o;
      rdy_oe <= next_rdy_oe;
      rdata <= next_rdata;
      rdata_oe <= next_rdata_oe;
      is_read <= next_is_read;
      wstb <= next_wstb;
      waddr <= next_waddr;
      wdata <= next_wdata;
      wcount <= next_wcount;
      cap_tog_seen <= next_cap_tog_seen;
      cap_rsel <= next_cap_rsel;
    end
  end

  // Register array update; no reset keeps it a plain memory
  always_ff @(posedge clk_i) begin
    if (clk_en_i && next_wstb) begin
      regs[next_waddr] <= next_wdata;
    end
  end

  // Output wiring, all from flip-flops
  assign pins.host_bus_grant_n = grant_n;
  assign pins.host_ready_o = rdy_o;
  assign pins.host_ready_oe = rdy_oe; // R5
  assign pins.dev_data_o = rdata;
  assign pins.dev_data_oe = rdata_oe;
  assign granted_o = ~grant_n;
  assign wr_strobe_o = wstb;
  assign wr_addr_o = waddr;
  assign wr_data_o = wdata;
  assign write_count_o = wcount;
endmodule // ahap_device

// ### design/ahap_host.sv
// Host end: requests the bus and runs single register reads and writes
`timescale 1ns/1ps
module ahap_host import ahap_pkg::*; #(
  parameter int ADDR_W = AHAP_ADDR_W,
  parameter int DATA_W = AHAP_DATA_W
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  // Device pins
  ahap_if.host pins,
  // User command port
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [ADDR_W-1:0] cmd_addr_i,
  input wire logic [DATA_W-1:0] cmd_wdata_i,
  input wire logic cmd_last_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_rdata_o
);
  // Two-stage synchronisers for grant and ready
  logic [1:0] sy_a, sy_b;
  logic grant_s, ready_s;
  assign {grant_s, ready_s} = sy_b;

  ahap_hst_state_e state, next_state;
  logic req_n, next_req_n, cs_n, next_cs_n, rd_n, next_rd_n, wr_n, next_wr_n;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [DATA_W-1:0] wdata, next_wdata;
  logic doe, next_doe, wr_op, next_wr_op, last, next_last, seen_low, next_seen_low;
  logic crdy, next_crdy, rv, next_rv;
  logic [DATA_W-1:0] rdat, next_rdat;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sy_a <= 2'b11;
      sy_b <= 2'b11;
    end else if (clk_en_i) begin
      sy_a <= {pins.host_bus_grant_n, pins.host_ready};
      sy_b <= sy_a;
    end
  end

  // Sequencing of request, grant, strobe and release
  always_comb begin
    next_state = state;
    {next_req_n, next_cs_n, next_rd_n, next_wr_n} = {req_n, cs_n, rd_n, wr_n};
    next_addr = addr;
    next_wdata = wdata;
    next_doe = doe;
    next_wr_op = wr_op;
    next_last = last;
    next_seen_low = seen_low;
    next_crdy = 1'b0;
    next_rv = 1'b0;
    next_rdat = rdat;
    case (state)
      AHAP_HST_IDLE: begin
        if (cmd_valid_i && !crdy) begin
          next_crdy = 1'b1;
          next_wr_op = cmd_write_i;
          next_last = cmd_last_i;
          next_wdata = cmd_wdata_i;
          next_addr = cmd_addr_i;
          next_addr[AHAP_MPS_ESCAPE_BIT] = 1'b1; // R3 R4
          next_req_n = 1'b0;
          next_cs_n = 1'b0;
          next_state = req_n ? AHAP_HST_REQUEST : AHAP_HST_SETUP;
        end
      end
      AHAP_HST_REQUEST: begin
        if (!grant_s) begin // R1
          next_state = AHAP_HST_SETUP;
        end
      end
      AHAP_HST_SETUP: begin
        // Address and select settled a cycle before the strobe
        next_seen_low = 1'b0;
        next_doe = wr_op;
        next_rd_n = wr_op;
        next_wr_n = !wr_op;
        next_state = AHAP_HST_STROBE; // R11
      end
      AHAP_HST_STROBE: begin
        if (!ready_s) begin
          next_seen_low = 1'b1;
        end else if (seen_low) begin
          next_rdat = pins.data;
          {next_rd_n, next_wr_n} = 2'b11; // R9 R10
          next_state = AHAP_HST_RELEASE;
        end
      end
      AHAP_HST_RELEASE: begin
        // Address and select held a cycle beyond the strobe
        next_doe = 1'b0;
        next_rv = !wr_op;
        next_state = last ? AHAP_HST_DROP : AHAP_HST_IDLE; // R11
      end
      AHAP_HST_DROP: begin
        // Stay off until grant is seen withdrawn, so no strobe meets a stale grant
        next_req_n = 1'b1;
        next_cs_n = 1'b1;
        next_addr[AHAP_MPS_ESCAPE_BIT] = 1'b0;
        if (grant_s) begin // R1
          next_state = AHAP_HST_IDLE;
        end
      end
      default: begin
        next_state = AHAP_HST_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= AHAP_HST_IDLE;
      {req_n, cs_n, rd_n, wr_n} <= 4'hF;
      addr <= '0;
      wdata <= '0;
      doe <= 1'b0;
      wr_op <= 1'b0;
      last <= 1'b0;
      seen_low <= 1'b0;
      crdy <= 1'b0;
      rv <= 1'b0;
      rdat <= '0;
    end else if (clk_en_i) begin
      state <= next_state;
      {req_n, cs_n, rd_n, wr_n} <= {next_req_n, next_cs_n, next_rd_n, next_wr_n};
      addr <= next_addr;
      wdata <= next_wdata;
      doe <= next_doe;
      wr_op <= next_wr_op;
      last <= next_last;
      seen_low <= next_seen_low;
      crdy <= next_crdy;
      rv <= next_rv;
      rdat <= next_rdat;
    end
  end

  assign pins.host_bus_request_n = req_n;
  assign pins.cs_n = cs_n;
  assign pins.rd_n = rd_n;
  assign pins.wr_n = wr_n;
  assign pins.addr = addr;
  assign pins.host_data_o = wdata;
  assign pins.host_data_oe = doe;
  assign cmd_ready_o = crdy;
  assign rsp_valid_o = rv;
  assign rsp_rdata_o = rdat;
endmodule // ahap_host

// ### tb/ahap_properties.sv
// Concurrent checks on the pins between the host end and the device end
`timescale 1ns/1ps
module ahap_properties import ahap_pkg::*; #(
  parameter int ADDR_W = AHAP_ADDR_W,
  parameter bit OPEN_DRAIN = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Host driven pins
  input wire logic cs_n,
  input wire logic host_bus_request_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [ADDR_W-1:0] addr,
  // Device driven pins and resolved ready
  input wire logic host_bus_grant_n,
  input wire logic dev_data_oe,
  input wire logic host_ready_o,
  input wire logic host_ready_oe,
  input wire logic host_ready
);
  // One clock domain, so one default clock and reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // Strobes only under grant, with the address kept out of shared space
  property p_strobe_granted;
    (!rd_n || !wr_n) |-> !host_bus_grant_n && !cs_n && addr[AHAP_MPS_ESCAPE_BIT];
  endproperty
  a_strobe_granted: assert property (p_strobe_granted)
    else $error("strobe without grant or escape bit");

  // Waiting request sees ready held low
  property p_req_ready_low;
    (!cs_n && !host_bus_request_n && host_bus_grant_n) [*6] |-> host_ready_oe && !host_ready_o;
  endproperty
  a_req_ready_low: assert property (p_req_ready_low)
    else $error("ready not low while request waits");

  // Grant releases ready in the way the build option asks
  property p_grant_release;
    $fell(host_bus_grant_n) |-> (OPEN_DRAIN ? !host_ready_oe : host_ready_oe && host_ready_o);
  endproperty
  a_grant_release: assert property (p_grant_release)
    else $error("ready not released at grant");

  // Ready stops driving once select or request ends
  property p_drop_float;
    (cs_n || host_bus_request_n) [*4] |-> !host_ready_oe;
  endproperty
  a_drop_float: assert property (p_drop_float)
    else $error("ready still driven after request ended");

  // Read strobe pulls ready low within a few syncing cycles
  property p_read_ready;
    $fell(rd_n) |-> ##[1:5] (host_ready_oe && !host_ready_o);
  endproperty
  a_read_ready: assert property (p_read_ready)
    else $error("no ready low after read strobe");

  // Data must already be driven when read ready releases
  property p_read_data;
    $rose(host_ready) && !rd_n |-> dev_data_oe && $past(dev_data_oe);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read ready released before data");

  // Write strobe pulls ready low likewise
  property p_write_ready;
    $fell(wr_n) |-> ##[1:5] (host_ready_oe && !host_ready_o);
  endproperty
  a_write_ready: assert property (p_write_ready)
    else $error("no ready low after write strobe");

  // Host keeps read strobe until ready is released
  property p_read_hold;
    $rose(rd_n) |-> $past(host_ready);
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("read strobe raised before ready release");

  // Address and select stand through the read strobe and the edge after it
  property p_read_addr_hold;
    (!rd_n || $rose(rd_n)) |-> !cs_n && $stable(addr);
  endproperty
  a_read_addr_hold: assert property (p_read_addr_hold)
    else $error("read address or select moved around strobe");

  // Grant only after a request seen through the clocked sampler
  property p_grant_cause;
    $fell(host_bus_grant_n) |-> $past(host_bus_request_n, 2) == 1'b0 && $past(cs_n, 2) == 1'b0;
  endproperty
  a_grant_cause: assert property (p_grant_cause)
    else $error("grant without sampled request");
endmodule // ahap_properties

// ### tb/async_host_access_port_tb.sv
// Bench joining host and device ends, checked against a register model
`timescale 1ns/1ps
module async_host_access_port_tb import ahap_pkg::*;;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic grant_allow_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic cmd_write_i = 1'b0;
  logic cmd_last_i = 1'b0;
  logic [23:0] cmd_addr_i = 24'h000000;
  logic [31:0] cmd_wdata_i = 32'h00000000;
  logic cmd_ready_o, rsp_valid_o, wr_strobe_o, granted_o;
  logic [31:0] rsp_rdata_o, wr_data_o;
  logic [3:0] wr_addr_o;
  logic [15:0] write_count_o, write_count2;
  int fail_count = 0;
  int samples_checked = 0;
  int nwr = 0;
  logic [31:0] mem [16];
  bit known [16];
  logic [35:0] exp_q [$];
  ahap_if bus ();
  ahap_if bus2 ();

  // Free running 20 MHz clock
  always #25 clk_i = ~clk_i;

  ahap_host ahap_host_i (.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(1'b1), .pins(bus),
    .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i),
    .cmd_wdata_i(cmd_wdata_i), .cmd_last_i(cmd_last_i), .cmd_ready_o(cmd_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o));
  ahap_device ahap_device_i (.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(1'b1), .pins(bus),
    .grant_allow_i(grant_allow_i), .granted_o(granted_o), .wr_strobe_o(wr_strobe_o),
    .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .write_count_o(write_count_o));
  // Open-drain build, driven straight by the bench at half-clock write spacing
  ahap_device #(.READY_OPEN_DRAIN(1'b1)) ahap_device_fast_i (.clk_i(clk_i), .reset_i(reset_i),
    .clk_en_i(1'b1), .pins(bus2), .grant_allow_i(1'b1), .granted_o(), .wr_strobe_o(),
    .wr_addr_o(), .wr_data_o(), .write_count_o(write_count2));
  ahap_properties ahap_properties_i (.clk_i(clk_i), .reset_i(reset_i), .cs_n(bus.cs_n),
    .host_bus_request_n(bus.host_bus_request_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
    .addr(bus.addr), .host_bus_grant_n(bus.host_bus_grant_n), .dev_data_oe(bus.dev_data_oe),
    .host_ready_o(bus.host_ready_o), .host_ready_oe(bus.host_ready_oe),
    .host_ready(bus.host_ready));

  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Each device write event must match the oldest write issued
  always @(negedge clk_i) begin
    if (!reset_i && wr_strobe_o === 1'b1) begin
      check("write event", exp_q.size() > 0 ? exp_q.pop_front() : '1, {wr_addr_o, wr_data_o});
    end
  end

  // One command; grant permission is raised after gd cycles when gd is non-zero
  task automatic do_cmd(input bit wr, input int idx, input logic [31:0] d, input bit last,
                        input int gd);
    int n;
    n = 0;
    cmd_valid_i = 1'b1;
    cmd_write_i = wr;
    cmd_addr_i = 24'h800000 | 24'(idx);
    cmd_wdata_i = d;
    cmd_last_i = last;
    if (wr) begin
      mem[idx] = d;
      known[idx] = 1'b1;
      exp_q.push_back({4'(idx), d});
      nwr++;
    end
    do begin
      @(posedge clk_i);
      #2;
      n++;
      if (cmd_ready_o === 1'b1) cmd_valid_i = 1'b0;
      if (n == 10 && gd > 10) check("ready and grant", 36'h1, {bus.host_ready, bus.host_bus_grant_n});
      if (n == gd) grant_allow_i = 1'b1;
    end while (n < 300 && (wr ? exp_q.size() > 0 : rsp_valid_o !== 1'b1));
    if (n >= 300) check("completion", 36'h0, 36'h1);
    check("granted", 36'h1, {35'h0, granted_o});
    if (!wr) check("read data", {4'h0, mem[idx]}, {4'h0, rsp_rdata_o});
  endtask

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (8000) @(posedge clk_i);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    int n;
    int k;
    bit w;
    bit lst;
    bit prev_last;
    prev_last = 1'b0;
    bus2.cs_n = 1'b1;
    bus2.host_bus_request_n = 1'b1;
    bus2.rd_n = 1'b1;
    bus2.wr_n = 1'b1;
    bus2.addr = 24'h800000;
    bus2.host_data_o = 32'h00000000;
    bus2.host_data_oe = 1'b1;
    void'($urandom(32'h04E9));
    repeat (5) @(posedge clk_i);
    #2;
    reset_i = 1'b0;
    // Request waits for grant, then write and read back boundary data
    do_cmd(1'b1, 0, 32'hFFFFFFFF, 1'b0, 12);
    do_cmd(1'b0, 0, 32'h0, 1'b1, 0);
    $display("test wait_for_grant done");
    // Random mix of reads and writes, with re-requests after each drop
    for (int i = 0; i < 24; i++) begin
      k = $urandom_range(0, 15);
      w = !known[k] || ($urandom_range(0, 1) == 1);
      lst = ($urandom_range(0, 3) == 0);
      if (prev_last) grant_allow_i = 1'b0;
      do_cmd(w, k, $urandom, lst, prev_last ? $urandom_range(4, 10) : 0);
      prev_last = lst;
    end
    $display("test random_traffic done");
    // Two writes half a clock apart into the open-drain device
    bus2.cs_n = 1'b0;
    bus2.host_bus_request_n = 1'b0;
    n = 0;
    while (bus2.host_bus_grant_n !== 1'b0 && n < 20) begin
      @(posedge clk_i);
      #2;
      n++;
    end
    check("open drain ready after grant", 36'h0, {35'h0, bus2.host_ready_oe});
    for (int j = 0; j < 2; j++) begin
      bus2.addr = 24'h800000 | 24'(j + 3);
      bus2.host_data_o = 32'hA5A50000 + 32'(j);
      bus2.wr_n = 1'b0;
      #12.5;
      bus2.wr_n = 1'b1;
      #12.5;
    end
    repeat (10) @(posedge clk_i);
    #2;
    bus2.cs_n = 1'b1;
    bus2.host_bus_request_n = 1'b1;
    check("fast write count", 36'h2, {20'h0, write_count2});
    $display("test half_clock_writes done");
    repeat (10) @(posedge clk_i);
    #2;
    check("write total", 36'(nwr), {20'h0, write_count_o});
    $display("test write_total done");
    tally_and_finish();
  end
endmodule // async_host_access_port_tb
